//--- rtl/cpw_ctrl.sv
// digital control of a can transceiver: modes, wake, fault guards
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// synchroniser for pin inputs
// -----------------------------------------------------------------
module cpw_sync (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_pin,
    input wire logic i_init,
    output logic o_level
);
    logic s1, s2, s3;
    // a change counts once the second and third stage agree
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            o_level <= 1'b0;
        end else if (i_ce) begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
    logic unused;
    assign unused = i_init;
endmodule

module cpw_ctrl #(
    parameter bit PATTERN_WAKE = 1'b0,
    parameter int WAKE_PATTERN_TIMEOUT_CYCLES =
        cpw_pkg::WAKE_PATTERN_TIMEOUT_CYC,
    parameter int PERM_DOM_TIMEOUT_CYCLES = cpw_pkg::PERM_DOM_TIMEOUT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_txd,
    input wire logic i_standby_select,
    input wire logic i_bus_dominant,
    input wire logic i_overtemp,
    input wire logic i_core_por,
    input wire logic i_io_por,
    input wire logic i_core_uv,
    output logic o_rxd,
    output logic o_drive_dominant,
    output logic o_driver_enable,
    output logic o_bus_hiz,
    output logic o_rx_highspeed,
    output logic o_rx_lowpower,
    output logic o_wake,
    output cpw_pkg::cpw_mode_e o_mode
);
    import cpw_pkg::*;

    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    logic txd_s;
    logic standby_select_s;
    logic dom_s;
    logic ot_s;
    logic uv_s;
    logic por_s;
    logic por_any;

    assign por_any = i_core_por | i_io_por;

    cpw_sync u_sync_txd (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_pin(~i_txd), .i_init(1'b0), .o_level(txd_s));
    cpw_sync u_sync_standby_select (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_pin(~i_standby_select), .i_init(1'b0), .o_level(standby_select_s));
    cpw_sync u_sync_dom (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_pin(i_bus_dominant), .i_init(1'b0), .o_level(dom_s));
    cpw_sync u_sync_ot (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_pin(i_overtemp), .i_init(1'b0), .o_level(ot_s));
    cpw_sync u_sync_uv (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_pin(~i_core_uv), .i_init(1'b0), .o_level(uv_s));
    cpw_sync u_sync_por (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_pin(~por_any), .i_init(1'b0), .o_level(por_s));

    // synchronisers reset to zero, so inverted pins give safe defaults:
    // transmit recessive, standby asserted, undervoltage and reset active
    logic txd_low;
    logic standby_req;
    logic core_uv;
    logic in_por;
    assign txd_low = txd_s;
    assign standby_req = ~standby_select_s;
    assign core_uv = ~uv_s;
    assign in_por = ~por_s;

    // -------------------------------------------------------------
    // mode state machine
    // -------------------------------------------------------------
    cpw_mode_e mode;
    cpw_mode_e next_mode;

    always_comb begin
        next_mode = mode;
        case (mode)
            CPW_UNPOWERED: begin
                if (!in_por) begin
                    next_mode = CPW_WAKE;
                end
            end
            CPW_WAKE: begin
                if (standby_req) begin
                    next_mode = CPW_STANDBY;
                end else if (!core_uv && !txd_low) begin
                    next_mode = CPW_NORMAL;
                end
            end
            CPW_NORMAL: begin
                if (core_uv) begin
                    next_mode = CPW_WAKE;
                end else if (standby_req) begin
                    next_mode = CPW_STANDBY;
                end
            end
            CPW_STANDBY: begin
                if (!standby_req) begin
                    next_mode = CPW_WAKE;
                end
            end
            default: begin
                next_mode = CPW_UNPOWERED;
            end
        endcase
        if (in_por) begin
            next_mode = CPW_UNPOWERED;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode <= CPW_UNPOWERED;
        end else if (i_ce) begin
            mode <= next_mode;
        end
    end

    logic is_normal;
    logic is_standby;
    assign is_normal = (mode == CPW_NORMAL);
    assign is_standby = (mode == CPW_STANDBY);

    // -------------------------------------------------------------
    // transmit permanent-dominant guard
    // -------------------------------------------------------------
    logic [CNT_W-1:0] tx_cnt;
    logic tx_fault;
    logic tx_expired;
    assign tx_expired = (tx_cnt >= CNT_W'(PERM_DOM_TIMEOUT_CYCLES));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_cnt <= RST_COUNT;
            tx_fault <= 1'b0;
        end else if (i_ce) begin
            if (!txd_low || !is_normal) begin
                tx_cnt <= RST_COUNT;
            end else if (!tx_expired) begin
                tx_cnt <= tx_cnt + CNT_W'(1);
            end
            if (!txd_low) begin
                tx_fault <= 1'b0;
            end else if (is_normal && tx_expired) begin
                tx_fault <= 1'b1;
            end
        end
    end

    // overtemperature only gates drivers in normal; receive untouched
    assign o_driver_enable = is_normal && !core_uv && !tx_fault
        && !ot_s;
    assign o_drive_dominant = o_driver_enable && txd_low;
    assign o_bus_hiz = (mode == CPW_UNPOWERED) || core_uv;

    // -------------------------------------------------------------
    // receiver selection: one receiver, two operating points
    // -------------------------------------------------------------
    assign o_rx_highspeed = is_normal;
    assign o_rx_lowpower = is_standby;

    // -------------------------------------------------------------
    // bus permanent-dominant guard in standby
    // -------------------------------------------------------------
    logic [CNT_W-1:0] bus_cnt;
    logic bus_fault;
    logic bus_expired;
    assign bus_expired = (bus_cnt >= CNT_W'(PERM_DOM_TIMEOUT_CYCLES));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bus_cnt <= RST_COUNT;
            bus_fault <= 1'b0;
        end else if (i_ce) begin
            if (!dom_s || !is_standby) begin
                bus_cnt <= RST_COUNT;
                bus_fault <= 1'b0;
            end else if (!bus_expired) begin
                bus_cnt <= bus_cnt + CNT_W'(1);
            end else begin
                bus_fault <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------
    // wake detection
    // -------------------------------------------------------------
    // phase counter restarts on every bus level change
    logic [CNT_W-1:0] ph_cnt;
    logic [CNT_W-1:0] to_cnt;
    logic dom_d;
    logic ph_ok;
    logic to_hit;
    cpw_wp_e wp;
    cpw_wp_e next_wp;
    logic wake_hit;
    logic wake_arm;

    assign ph_ok = (ph_cnt >= CNT_W'(WAKE_FILTER_CYC));
    assign to_hit = (to_cnt >= CNT_W'(WAKE_PATTERN_TIMEOUT_CYCLES));
    assign wake_arm = is_standby && !bus_fault;

    always_comb begin
        next_wp = wp;
        wake_hit = 1'b0;
        case (wp)
            CPW_WP_IDLE: begin
                if (dom_s) begin
                    next_wp = CPW_WP_DOM1;
                end
            end
            CPW_WP_DOM1: begin
                // at a level change ph_cnt still holds the ended phase
                if (!dom_s && PATTERN_WAKE && ph_ok) begin
                    next_wp = CPW_WP_REC;
                end else if (!dom_s) begin
                    next_wp = CPW_WP_IDLE;
                end else if (!PATTERN_WAKE && ph_ok) begin
                    wake_hit = 1'b1;
                    next_wp = CPW_WP_IDLE;
                end
            end
            CPW_WP_REC: begin
                if (dom_s && ph_ok) begin
                    next_wp = CPW_WP_DOM2;
                end else if (dom_s) begin
                    next_wp = CPW_WP_IDLE;
                end
            end
            CPW_WP_DOM2: begin
                if (dom_s && ph_ok) begin
                    wake_hit = 1'b1;
                    next_wp = CPW_WP_IDLE;
                end else if (!dom_s) begin
                    next_wp = CPW_WP_REC;
                end
            end
            default: begin
                next_wp = CPW_WP_IDLE;
            end
        endcase
        if (!wake_arm || (wp != CPW_WP_IDLE && to_hit)) begin
            next_wp = CPW_WP_IDLE;
            wake_hit = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wp <= CPW_WP_IDLE;
            dom_d <= 1'b0;
            ph_cnt <= RST_COUNT;
            to_cnt <= RST_COUNT;
        end else if (i_ce) begin
            wp <= next_wp;
            dom_d <= dom_s;
            if (dom_s != dom_d) begin
                ph_cnt <= RST_COUNT;
            end else if (!ph_ok) begin
                ph_cnt <= ph_cnt + CNT_W'(1);
            end
            if (wp == CPW_WP_IDLE) begin
                to_cnt <= RST_COUNT;
            end else if (!to_hit) begin
                to_cnt <= to_cnt + CNT_W'(1);
            end
        end
    end

    // wake flag holds until standby is left, by the controller or by a supply reset
    logic wake;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wake <= 1'b0;
        end else if (i_ce) begin
            if (wake_hit) begin
                wake <= 1'b1;
            end else if (!is_standby) begin
                wake <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // receive output
    // -------------------------------------------------------------
    logic next_rxd;
    always_comb begin
        next_rxd = RST_RX_LEVEL;
        if (is_normal && !core_uv) begin
            next_rxd = ~dom_s;
        end else if (is_standby && !bus_fault && wake) begin
            next_rxd = ~dom_s;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rxd <= RST_RX_LEVEL;
        end else if (i_ce) begin
            o_rxd <= next_rxd;
        end
    end

    assign o_wake = wake;
    assign o_mode = mode;
endmodule

`default_nettype wire

//--- rtl/cpw_pkg.sv
// constants and types for the transceiver control logic
package cpw_pkg;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_FILTER_TIME_NS = 3600;
    // longest time: rounds down
    localparam int WAKE_FILTER_CYC = WAKE_FILTER_TIME_NS / CLK_PERIOD_NS;
    localparam int WAKE_PATTERN_TIMEOUT_US = 1000;
    localparam int WAKE_PATTERN_TIMEOUT_CYC =
        WAKE_PATTERN_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int PERM_DOM_TIMEOUT_US = 2000;
    localparam int PERM_DOM_TIMEOUT_CYC =
        PERM_DOM_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic RST_RX_LEVEL = 1'b1;
    localparam logic [CNT_W-1:0] RST_COUNT = 20'h00000;

    // -------------------------------------------------------------
    // mode and wake pattern states
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        CPW_UNPOWERED = 4'h1,
        CPW_WAKE = 4'h2,
        CPW_NORMAL = 4'h4,
        CPW_STANDBY = 4'h8
    } cpw_mode_e;

    typedef enum logic [3:0] {
        CPW_WP_IDLE = 4'h1,
        CPW_WP_DOM1 = 4'h2,
        CPW_WP_REC = 4'h4,
        CPW_WP_DOM2 = 4'h8
    } cpw_wp_e;
endpackage

//--- sim/cpw_bus_model.sv
// wired bus seen by the transceiver comparator
`timescale 1ns/1ps
`default_nettype none
module cpw_bus_model (
    input wire logic i_drive_dominant,
    input wire logic i_driver_enable,
    input wire logic i_bus_hiz,
    input wire logic i_remote_dominant,
    output logic o_bus_dominant
);
    // any node pulling dominant beats a recessive request
    assign o_bus_dominant = (i_drive_dominant && i_driver_enable &&
        !i_bus_hiz) || i_remote_dominant;
endmodule
`default_nettype wire

//--- sim/cpw_ctrl_properties.sv
// port assertions for the transceiver control logic
`timescale 1ns/1ps
`default_nettype none
module cpw_ctrl_properties (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_txd,
    input wire logic i_bus_dominant,
    input wire logic i_overtemp,
    input wire logic i_core_por,
    input wire logic i_core_uv,
    input wire logic o_rxd,
    input wire logic o_drive_dominant,
    input wire logic o_driver_enable,
    input wire logic o_bus_hiz,
    input wire logic o_rx_highspeed,
    input wire logic o_rx_lowpower,
    input wire logic o_wake,
    input wire cpw_pkg::cpw_mode_e o_mode
);
    import cpw_pkg::*;
    // ---------------------------------------------------------------
    // checks; 6 or 8 stable cycles cover the pin synchroniser latency
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_por_holds: assert property (
        (i_core_por && i_ce) [*8] |-> o_mode == CPW_UNPOWERED)
        else $error("mode left unpowered under supply reset");
    a_txd_dom: assert property (
        (!i_txd && i_ce) [*6] ##0 o_driver_enable |-> o_drive_dominant)
        else $error("bus not dominant with transmit low");
    a_txd_rec: assert property (
        (i_txd && i_ce) [*6] |-> !o_drive_dominant)
        else $error("bus dominant with transmit high");
    a_hot_off: assert property (
        (i_overtemp && i_ce) [*6] |-> !o_driver_enable)
        else $error("drivers on while too hot");
    a_drv_normal: assert property (
        o_driver_enable |-> o_mode == CPW_NORMAL && !o_bus_hiz)
        else $error("drivers on outside normal mode");
    a_rx_select: assert property (
        o_rx_highspeed == (o_mode == CPW_NORMAL)
        && o_rx_lowpower == (o_mode == CPW_STANDBY))
        else $error("receiver choice does not match mode");
    a_uv_hiz: assert property (
        (i_core_uv && i_ce) [*8] ##0 o_mode != CPW_STANDBY |-> o_bus_hiz)
        else $error("bus pins driven in undervoltage");
    a_uv_rx_high: assert property (
        (i_core_uv && i_ce) [*8] ##0 o_mode != CPW_STANDBY |=> o_rxd)
        else $error("receive output low in undervoltage");
    a_rx_follow: assert property (
        (i_bus_dominant && i_ce && o_mode == CPW_NORMAL) [*8] |-> !o_rxd)
        else $error("receive output misses dominant bus");
    a_wake_rx_low: assert property (
        $rose(o_wake) |-> ##[0:2] !o_rxd)
        else $error("no falling receive edge on wake");
    c_wake: cover property ($rose(o_wake));
    c_txd_fault: cover property (
        o_mode == CPW_NORMAL && !o_driver_enable && !i_overtemp);
    c_leave_standby: cover property (
        o_mode == CPW_STANDBY ##1 o_mode != CPW_STANDBY);
endmodule
`default_nettype wire

//--- sim/tb_can_phy_wake_fault_control.sv
// self-checking bench for the transceiver control logic
`timescale 1ns/1ps
`default_nettype none
module tb_can_phy_wake_fault_control;
    import cpw_pkg::*;
    // ---------------------------------------------------------------
    // short timeouts keep the run small
    // ---------------------------------------------------------------
    localparam int PD = 1000;
    localparam int WT = 2000;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, txd = 1'b1, sel = 1'b0;
    logic hot = 1'b0, cpor = 1'b1, iopor = 1'b1, uv = 1'b1, remote = 1'b0;
    logic bus, rxd, drv, den, hiz, rhs, rlp, wake, rxd_b, wake_b;
    cpw_mode_e mode;
    int bad_count = 0, comparisons = 0, cycles = 0;
    always #5 clk = ~clk;
    cpw_ctrl #(.PATTERN_WAKE(1'b1), .WAKE_PATTERN_TIMEOUT_CYCLES(WT),
        .PERM_DOM_TIMEOUT_CYCLES(PD)) dut (.i_clk(clk), .i_rst(rst),
        .i_ce(ce), .i_txd(txd), .i_standby_select(sel),
        .i_bus_dominant(bus), .i_overtemp(hot), .i_core_por(cpor),
        .i_io_por(iopor), .i_core_uv(uv), .o_rxd(rxd),
        .o_drive_dominant(drv), .o_driver_enable(den), .o_bus_hiz(hiz),
        .o_rx_highspeed(rhs), .o_rx_lowpower(rlp), .o_wake(wake),
        .o_mode(mode));
    cpw_bus_model bus_m (.i_drive_dominant(drv), .i_driver_enable(den),
        .i_bus_hiz(hiz), .i_remote_dominant(remote), .o_bus_dominant(bus));
    // basic-wake build sees the same pins; its drive outputs stay unused
    cpw_ctrl #(.PATTERN_WAKE(1'b0), .WAKE_PATTERN_TIMEOUT_CYCLES(WT),
        .PERM_DOM_TIMEOUT_CYCLES(PD)) dut_basic (.i_clk(clk), .i_rst(rst),
        .i_ce(ce), .i_txd(txd), .i_standby_select(sel),
        .i_bus_dominant(bus), .i_overtemp(hot), .i_core_por(cpor),
        .i_io_por(iopor), .i_core_uv(uv), .o_rxd(rxd_b),
        .o_drive_dominant(), .o_driver_enable(), .o_bus_hiz(),
        .o_rx_highspeed(), .o_rx_lowpower(), .o_wake(wake_b), .o_mode());
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_mode(input cpw_mode_e got, input cpw_mode_e exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            summarize();
        end
    end
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_power;
        @(posedge clk) cpor <= 1'b0;
        wt(20);
        chk_mode(mode, CPW_UNPOWERED);
        chk(hiz, 1'b1);
        @(posedge clk) iopor <= 1'b0;
        txd <= 1'b0;
        wt(20);
        chk(hiz, 1'b1);
        @(posedge clk) uv <= 1'b0;
        wt(20);
        chk_mode(mode, CPW_WAKE);
        @(posedge clk) txd <= 1'b1;
        wt(20);
        chk_mode(mode, CPW_NORMAL);
        chk(hiz, 1'b0);
        chk(rhs, 1'b1);
    endtask
    task automatic t_tx;
        @(posedge clk) txd <= 1'b0;
        wt(10);
        chk(drv, 1'b1);
        chk(rxd, 1'b0);
        @(posedge clk) txd <= 1'b1;
        wt(10);
        chk(drv, 1'b0);
        chk(rxd, 1'b1);
        @(posedge clk) remote <= 1'b1;
        wt(10);
        chk(rxd, 1'b0);
        @(posedge clk) remote <= 1'b0;
    endtask
    task automatic t_txd_fault;
        @(posedge clk) txd <= 1'b0;
        wt(PD + 40);
        chk(den, 1'b0);
        @(posedge clk) remote <= 1'b1;
        wt(10);
        chk(rxd, 1'b0);
        @(posedge clk) remote <= 1'b0;
        wt(10);
        chk(rxd, 1'b1);
        chk(den, 1'b0);
        @(posedge clk) txd <= 1'b1;
        wt(10);
        chk(den, 1'b1);
    endtask
    task automatic t_hot;
        @(posedge clk) hot <= 1'b1;
        remote <= 1'b1;
        wt(10);
        chk(den, 1'b0);
        chk(rhs, 1'b1);
        chk(rxd, 1'b0);
        @(posedge clk) hot <= 1'b0;
        remote <= 1'b0;
        wt(10);
    endtask
    task automatic t_uv;
        @(posedge clk) uv <= 1'b1;
        remote <= 1'b1;
        wt(20);
        chk(rxd, 1'b1);
        chk(hiz, 1'b1);
        @(posedge clk) uv <= 1'b0;
        remote <= 1'b0;
        wt(20);
        chk_mode(mode, CPW_NORMAL);
    endtask
    task automatic t_wake;
        @(posedge clk) sel <= 1'b1;
        hot <= 1'b1;
        wt(20);
        chk_mode(mode, CPW_STANDBY);
        chk(rlp, 1'b1);
        // late second dominant: pattern must be dropped
        @(posedge clk) remote <= 1'b1;
        wt(400);
        @(posedge clk) remote <= 1'b0;
        wt(1700);
        @(posedge clk) remote <= 1'b1;
        wt(400);
        chk(wake, 1'b0);
        chk(rxd, 1'b1);
        chk(wake_b, 1'b1);
        chk(rxd_b, 1'b0);
        @(posedge clk) remote <= 1'b0;
        wt(2500);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) remote <= ~remote;
            wt(400);
        end
        chk(wake, 1'b1);
        chk(rxd, 1'b0);
        wt(1100);
        chk(rxd, 1'b1);
        wt(200);
        chk(rxd, 1'b1);
        @(posedge clk) remote <= 1'b0;
        sel <= 1'b0;
        hot <= 1'b0;
        wt(30);
        chk(wake, 1'b0);
        chk_mode(mode, CPW_NORMAL);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_power();
        t_tx();
        t_txd_fault();
        t_hot();
        t_uv();
        t_wake();
        summarize();
    end
endmodule
bind cpw_ctrl cpw_ctrl_properties u_props (.i_clk, .i_rst, .i_ce, .i_txd,
    .i_bus_dominant, .i_overtemp, .i_core_por, .i_core_uv, .o_rxd,
    .o_drive_dominant, .o_driver_enable, .o_bus_hiz, .o_rx_highspeed,
    .o_rx_lowpower, .o_wake, .o_mode);
`default_nettype wire
